// ==== bench/decode_chk.sv ====
// Port assertions for the decoder slice
`timescale 1ns/1ps
module decode_chk
  import stack_swap_operands_io_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic byte_ready,
  input wire logic instr_valid,
  input wire op_e instr_op,
  input wire logic [1:0] instr_mod,
  input wire logic [1:0] instr_seg,
  input wire logic instr_fault,
  input wire logic busy,
  input wire logic instr_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // ****************
  // Assertions
  // ****************
  busy_no_ready_a: assert property (busy |-> !byte_ready)
    else $error("ready while busy");
  fault_idle_a: assert property (instr_fault |-> !busy && byte_ready)
    else $error("fault started work");
  valid_pulse_a: assert property (instr_valid |-> busy ##1 !instr_valid)
    else $error("valid not a busy pulse");
  done_free_a: assert property (instr_done |=> !busy && byte_ready)
    else $error("not free after done");
  acc_time_a: assert property (
    instr_valid && instr_op == op_swap_operands_acc
    |-> !instr_done [*3] ##1 instr_done)
    else $error("swap acc count");
  flag_time_a: assert property (
    instr_valid && instr_op == op_store_high_acc_to_flags
    |-> ##3 instr_done)
    else $error("flag store count");
  swap_reg_a: assert property (
    instr_valid && instr_op == op_swap_operands_rm && instr_mod == 2'h3
    |-> ##4 instr_done)
    else $error("swap reg count");
  swap_mem_a: assert property (
    instr_valid && instr_op == op_swap_operands_rm && instr_mod != 2'h3
    |-> ##17 instr_done)
    else $error("swap mem count");
  in_time_a: assert property (
    instr_valid && instr_op == op_in_fixed
    |-> ##10 instr_done)
    else $error("fixed input count");
  far_mem_only_a: assert property (
    instr_op == op_load_far_ptr_extra_seg && (instr_valid || instr_fault)
    |-> instr_fault == (instr_mod == 2'h3))
    else $error("far load mode check");
  seg_forbid_a: assert property (
    instr_op == op_pop_seg && (instr_valid || instr_fault)
    |-> instr_fault == (instr_seg == 2'h1))
    else $error("segment code check");
  cover property (instr_fault);
  cover property (instr_valid && instr_op == op_restore_all_regs);
  cover property (instr_done);
endmodule : decode_chk

// ==== bench/fetch_model.sv ====
// Fetch path model offering queued bytes, with optional stall
`timescale 1ns/1ps
module fetch_model (
  input wire logic clk,
  input wire logic byte_ready,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [7:0] q[$];
  int stall = 0;
  int hold = 0;
  logic rdy = 1'b0;
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  // Ready is sampled after it settles to avoid an edge race
  always @(posedge clk) begin
    if (byte_valid && rdy) begin
      void'(q.pop_front());
      hold = stall;
    end else if (hold > 0)
      hold--;
    #1;
    rdy = byte_ready;
    byte_valid = q.size() > 0 && hold == 0;
    // Idle data toggles so a stale byte is never mistaken for a fresh one
    byte_data = byte_valid ? q[0] : ~byte_data;
  end
endmodule : fetch_model

// ==== bench/tb_stack_swap_operands_io_opcode_decode.sv ====
// Self-checking bench for the decoder slice
`timescale 1ns/1ps
module tb_stack_swap_operands_io_opcode_decode
  import stack_swap_operands_io_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, strap = 1'b0, bv;
  logic [7:0] bd;
  logic ready, valid, wide, fault, busy, done;
  op_e op;
  logic [2:0] reg_f, rm;
  logic [1:0] seg, mod;
  logic [7:0] port;
  int mismatches = 0, checked = 0, cyc = 0;
  initial forever #10 clk = ~clk;
  stack_swap_operands_io_opcode_decode stack_swap_operands_io_opcode_decode_inst (.clk(clk),
    .srst(srst), .narrow_bus_strap(strap), .byte_valid(bv), .byte_data(bd),
    .byte_ready(ready), .instr_valid(valid), .instr_op(op),
    .instr_wide(wide), .instr_reg(reg_f), .instr_seg(seg), .instr_mod(mod),
    .instr_rm(rm), .instr_port(port), .instr_fault(fault), .busy(busy),
    .instr_done(done));
  fetch_model fetch_model_inst (.clk(clk), .byte_ready(ready),
    .byte_valid(bv), .byte_data(bd));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic rst(input logic s);
    srst = 1'b1;
    strap = s;
    repeat (6) @(posedge clk);
    #1 srst = 1'b0;
    strap = ~s;
  endtask : rst
  // n of zero means a fault is expected
  task automatic run(input logic [7:0] b0, b1, input int nb, input op_e o,
      input int n);
    int c = 0;
    fetch_model_inst.q.push_back(b0);
    if (nb == 2) fetch_model_inst.q.push_back(b1);
    while (valid !== 1'b1 && fault !== 1'b1 && c < 300) begin
      @(posedge clk);
      #1 c++;
    end
    if (n == 0) begin
      chk(fault, 1'b1);
      chk(busy, 1'b0);
    end else begin
      chk(valid, 1'b1);
      chk(busy, 1'b1);
      chk(8'(op), 8'(o));
      c = 0;
      while (done !== 1'b1 && c < 300) begin
        @(posedge clk);
        #1 c++;
      end
      chk(8'(c), 8'(n));
    end
    @(posedge clk);
    #1;
    chk(ready, 1'b1);
    chk(busy, 1'b0);
  endtask : run
  task automatic t_stack(input logic s);
    rst(s);
    run(8'h5d, 8'h00, 1, op_pop_reg, s ? 14 : 10);
    chk(reg_f, 8'h05);
    run(8'h17, 8'h00, 1, op_pop_seg, s ? 12 : 8);
    chk(seg, 8'h02);
    run(8'h0f, 8'h00, 1, op_none, 0);
    run(8'h61, 8'h00, 1, op_restore_all_regs, s ? 83 : 51);
    run(8'hc4, 8'hc0, 2, op_none, 0);
    run(8'hc4, 8'h1e, 2, op_load_far_ptr_extra_seg, s ? 26 : 18);
    chk(reg_f, 8'h03);
  endtask : t_stack
  task automatic t_swap;
    fetch_model_inst.stall = 3;
    run(8'h86, 8'hc1, 2, op_swap_operands_rm, 4);
    chk(wide, 1'b0);
    chk(mod, 8'h03);
    chk(rm, 8'h01);
    run(8'h87, 8'h06, 2, op_swap_operands_rm, 17);
    chk(wide, 1'b1);
    fetch_model_inst.stall = 0;
    run(8'h93, 8'h00, 1, op_swap_operands_acc, 3);
    chk(reg_f, 8'h03);
  endtask : t_swap
  task automatic t_misc;
    run(8'he4, 8'h42, 2, op_in_fixed, 10);
    chk(port, 8'h42);
    chk(wide, 1'b0);
    run(8'h9e, 8'h00, 1, op_store_high_acc_to_flags, 3);
    run(8'hc5, 8'h00, 1, op_none, 0);
  endtask : t_misc
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    t_stack(1'b0);
    t_swap();
    t_misc();
    t_stack(1'b1);
    summarize();
  end
endmodule : tb_stack_swap_operands_io_opcode_decode
bind stack_swap_operands_io_opcode_decode decode_chk decode_chk_inst (.clk(clk),
  .srst(srst), .byte_ready(byte_ready), .instr_valid(instr_valid),
  .instr_op(instr_op), .instr_mod(instr_mod), .instr_seg(instr_seg),
  .instr_fault(instr_fault),
  .busy(busy), .instr_done(instr_done));

// ==== inc/exec_timer_if.sv ====
// Link between the decoder and its execution clock counter
`timescale 1ns/1ps
interface exec_timer_if;
  import stack_swap_operands_io_pkg::*;
  logic load;
  cycles_t cycles;
  logic done;

  modport ctrl (output load, output cycles, input done);
  modport timer (input load, input cycles, output done);
endinterface : exec_timer_if

// ==== inc/stack_swap_operands_io_consts.svh ====
// Opcode patterns and execution clock counts for the decoder slice
`ifndef STACK_SWAP_OPERANDS_IO_CONSTS_SVH
`define STACK_SWAP_OPERANDS_IO_CONSTS_SVH

// ****************************************
// Opcode patterns
// ****************************************
`define OPC_POP_REG_HI 5'h0b
`define OPC_POP_SEG_HI 3'h0
`define OPC_POP_SEG_LO 3'h7
`define OPC_RESTORE_ALL 8'h61
`define OPC_SWAP_RM_HI 7'h43
`define OPC_SWAP_ACC_HI 5'h12
`define OPC_IN_FIXED_HI 7'h72
`define OPC_LOAD_FAR_ES 8'hc4
`define OPC_STORE_HAF 8'h9e
`define SEG_FORBIDDEN 2'h1
`define MOD_REGISTER 2'h3

// ****************************************
// Execution clocks: _W is the 16-bit bus variant, _N the 8-bit one
// ****************************************
`define CYC_WIDTH 7
`define CYC_POP_REG_W 7'd10
`define CYC_POP_REG_N 7'd14
`define CYC_POP_SEG_W 7'd8
`define CYC_POP_SEG_N 7'd12
`define CYC_RESTORE_ALL_W 7'd51
`define CYC_RESTORE_ALL_N 7'd83
`define CYC_SWAP_REG 7'd4
`define CYC_SWAP_MEM 7'd17
`define CYC_SWAP_ACC 7'd3
`define CYC_IN_FIXED 7'd10
`define CYC_LOAD_FAR_W 7'd18
`define CYC_LOAD_FAR_N 7'd26
`define CYC_STORE_HAF 7'd3

`endif

// ==== inc/stack_swap_operands_io_pkg.sv ====
// Types shared by the decoder slice
package stack_swap_operands_io_pkg;

  typedef enum logic [3:0] {
    op_none,
    op_pop_reg,
    op_pop_seg,
    op_restore_all_regs,
    op_swap_operands_rm,
    op_swap_operands_acc,
    op_in_fixed,
    op_load_far_ptr_extra_seg,
    op_store_high_acc_to_flags
  } op_e;

  typedef logic [6:0] cycles_t;

endpackage : stack_swap_operands_io_pkg

// ==== verilog/exec_timer.sv ====
// Execution clock counter: pulses done after the loaded number of clocks
`timescale 1ns/1ps
module exec_timer
  import stack_swap_operands_io_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  exec_timer_if.timer t
);

  cycles_t count;

  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else if (t.load) begin
      count <= t.cycles;
    end else if (count != '0) begin
      count <= count - 7'h01;
    end
  end

  // Done lands in the cycle after the last counted clock
  always_ff @(posedge clk) begin
    if (srst || t.load) begin
      t.done <= 1'b0;
    end else begin
      t.done <= (count == 7'h01);
    end
  end

endmodule : exec_timer

// ==== verilog/stack_swap_operands_io_opcode_decode.sv ====
// Decoder and sequencer for stack restore, swap, fixed input and flag forms
//
// Behaviour
// - Byte 01011rrr restores register rrr from stack in 10 or 14 clocks.
// - Byte 000ss111 restores segment ss in 8 or 12 clocks; ss of 01 faults.
// - Byte 01100001 restores all general registers in 51 or 83 clocks.
// - Bytes 1000011w plus mod/reg/rm swap operands in 4 (reg) or 17 (mem).
// - Byte 10010rrr swaps register rrr with the accumulator in 3 clocks.
// - Bytes 1110010w plus a port byte input from that port in 10 clocks.
// - The far pointer load into ES needs mod not 11 and takes 18 or 26.
// - Storing the high accumulator byte into the flags takes 3 clocks.
`timescale 1ns/1ps
`include "stack_swap_operands_io_consts.svh"
module stack_swap_operands_io_opcode_decode
  import stack_swap_operands_io_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic narrow_bus_strap,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  output logic byte_ready,
  output logic instr_valid,
  output op_e instr_op,
  output logic instr_wide,
  output logic [2:0] instr_reg,
  output logic [1:0] instr_seg,
  output logic [1:0] instr_mod,
  output logic [2:0] instr_rm,
  output logic [7:0] instr_port,
  output logic instr_fault,
  output logic busy,
  output logic instr_done
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {st_idle, st_operand, st_exec} state_e;

  state_e state;
  state_e next_state;
  logic narrow;
  logic strap_meta;
  logic strap_sync;
  logic [7:0] opcode;
  op_e first_op;
  op_e op_now;
  logic [7:0] opc_now;
  logic needs_second;
  logic take;
  logic last_byte;
  logic fault_now;
  cycles_t cycles_now;

  exec_timer_if tmr ();

  exec_timer exec_timer_inst (
    .clk(clk),
    .srst(srst),
    .t(tmr)
  );

  assign take = byte_valid && byte_ready;
  assign instr_done = tmr.done;

  // Strap is a board pin, so it is retimed before the latch reads it
  always_ff @(posedge clk) begin
    strap_meta <= narrow_bus_strap;
    strap_sync <= strap_meta;
  end

  // Variant is fixed while reset is held; reset must span three clocks
  // so that the retimed strap reaches the latch
  always_ff @(posedge clk) begin
    if (srst) begin
      narrow <= strap_sync;
    end
  end

  // ****************************************
  // Opcode classification
  // ****************************************
  always_comb begin
    first_op = op_none;
    needs_second = 1'b0;
    if (byte_data[7:3] == `OPC_POP_REG_HI) begin
      first_op = op_pop_reg;
    end else if (byte_data[7:5] == `OPC_POP_SEG_HI &&
                 byte_data[2:0] == `OPC_POP_SEG_LO) begin
      first_op = op_pop_seg;
    end else if (byte_data == `OPC_RESTORE_ALL) begin
      first_op = op_restore_all_regs;
    end else if (byte_data[7:1] == `OPC_SWAP_RM_HI) begin
      first_op = op_swap_operands_rm;
      needs_second = 1'b1;
    end else if (byte_data[7:3] == `OPC_SWAP_ACC_HI) begin
      first_op = op_swap_operands_acc;
    end else if (byte_data[7:1] == `OPC_IN_FIXED_HI) begin
      first_op = op_in_fixed;
      needs_second = 1'b1;
    end else if (byte_data == `OPC_LOAD_FAR_ES) begin
      first_op = op_load_far_ptr_extra_seg;
      needs_second = 1'b1;
    end else if (byte_data == `OPC_STORE_HAF) begin
      first_op = op_store_high_acc_to_flags;
    end
  end

  // Opcode and class of the instruction completing on this byte
  always_comb begin
    opc_now = byte_data;
    op_now = first_op;
    if (state == st_operand) begin
      opc_now = opcode;
      op_now = instr_op;
    end
  end

  assign last_byte = take && (state == st_operand || !needs_second);

  // ****************************************
  // Legality and clock count of the completed instruction
  // ****************************************
  always_comb begin
    fault_now = 1'b0;
    cycles_now = `CYC_SWAP_ACC;
    case (op_now)
      op_pop_reg: begin
        cycles_now = narrow ? `CYC_POP_REG_N : `CYC_POP_REG_W;
      end
      op_pop_seg: begin
        fault_now = (opc_now[4:3] == `SEG_FORBIDDEN);
        cycles_now = narrow ? `CYC_POP_SEG_N : `CYC_POP_SEG_W;
      end
      op_restore_all_regs: begin
        cycles_now = narrow ? `CYC_RESTORE_ALL_N : `CYC_RESTORE_ALL_W;
      end
      op_swap_operands_rm: begin
        // Same count on both bus variants
        cycles_now = (byte_data[7:6] == `MOD_REGISTER) ?
                     `CYC_SWAP_REG : `CYC_SWAP_MEM;
      end
      op_swap_operands_acc: begin
        cycles_now = `CYC_SWAP_ACC;
      end
      op_in_fixed: begin
        cycles_now = `CYC_IN_FIXED;
      end
      op_load_far_ptr_extra_seg: begin
        fault_now = (byte_data[7:6] == `MOD_REGISTER);
        cycles_now = narrow ? `CYC_LOAD_FAR_N : `CYC_LOAD_FAR_W;
      end
      op_store_high_acc_to_flags: begin
        cycles_now = `CYC_STORE_HAF;
      end
      op_none: begin
        // Opcodes outside this slice are refused as a fault
        fault_now = 1'b1;
      end
      default: begin
        fault_now = 1'b1;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (take) begin
          if (needs_second) begin
            next_state = st_operand;
          end else if (!fault_now) begin
            next_state = st_exec;
          end
        end
      end
      st_operand: begin
        if (take) begin
          next_state = fault_now ? st_idle : st_exec;
        end
      end
      st_exec: begin
        if (tmr.done) begin
          next_state = st_idle;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= st_idle;
      byte_ready <= 1'b0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      // Bytes are held off while an instruction executes
      byte_ready <= (next_state != st_exec);
      busy <= (next_state == st_exec);
    end
  end

  // Timer is started only for legal instructions
  assign tmr.load = last_byte && !fault_now;
  assign tmr.cycles = cycles_now;

  // ****************************************
  // Instruction fields
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      opcode <= 8'h00;
      instr_op <= op_none;
    end else if (take && state == st_idle) begin
      opcode <= byte_data;
      instr_op <= first_op;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      instr_valid <= 1'b0;
      instr_fault <= 1'b0;
    end else begin
      instr_valid <= last_byte && !fault_now;
      instr_fault <= last_byte && fault_now;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      instr_wide <= 1'b0;
      instr_reg <= 3'h0;
      instr_seg <= 2'h0;
      instr_mod <= 2'h0;
      instr_rm <= 3'h0;
      instr_port <= 8'h00;
    end else if (last_byte) begin
      instr_seg <= opc_now[4:3];
      instr_mod <= 2'h0;
      instr_rm <= 3'h0;
      instr_port <= 8'h00;
      instr_reg <= opc_now[2:0];
      // Forms without a w bit always work on words
      instr_wide <= 1'b1;
      if (op_now == op_swap_operands_rm || op_now == op_in_fixed) begin
        instr_wide <= opc_now[0];
      end
      if (op_now == op_swap_operands_rm ||
          op_now == op_load_far_ptr_extra_seg) begin
        instr_mod <= byte_data[7:6];
        instr_reg <= byte_data[5:3];
        instr_rm <= byte_data[2:0];
      end
      if (op_now == op_in_fixed) begin
        instr_port <= byte_data;
      end
    end
  end

endmodule : stack_swap_operands_io_opcode_decode
